// [serial_params.svh]
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
// Data and register port widths
`define SER_DATA_W 8
`define SER_ADDR_W 4
// Register offsets
`define OFS_MODE 4'h0
`define OFS_BRR 4'h1
`define OFS_CTRL 4'h2
`define OFS_TDR 4'h3
`define OFS_STAT 4'h4
`define OFS_RDR 4'h5
`define OFS_ISTS 4'h6
`define OFS_IMASK 4'h7
// Mode register fields
`define MODE_SYNC 7
`define MODE_PAR_EN 5
`define MODE_ODD 4
`define MODE_MP 2
`define MODE_CKS_HI 1
`define MODE_CKS_LO 0
// Control register fields
`define CTL_TE 5
`define CTL_RE 4
// Status register fields
`define ST_TRANSMIT_EMPTY_FLAG 7
`define ST_RECEIVE_FULL_FLAG 6
`define ST_PER 3
`define ST_TRANSMIT_END_FLAG 2
`define ST_MPB 1
`define ST_MP_TX_BIT 0
// Interrupt status and mask fields
`define IRQ_W 4
`define IRQ_RXF 0
`define IRQ_TXE 1
`define IRQ_PER 2
`define IRQ_TRANSMIT_END_FLAG 3
// Reset values
`define BRR_RST 8'hFF
`define MODE_RST 8'h00
`define BYTE_ZERO 8'h00
`define IRQ_ZERO 4'h0
// Baud generator: prescaler limits per clock select, ticks per bit
`define PRE_W 6
`define PRE_LIM0 6'h00
`define PRE_LIM1 6'h03
`define PRE_LIM2 6'h0F
`define PRE_LIM3 6'h3F
`define SUB_W 5
`define SUB_LIM 5'h1F
`endif

// [serial_pkg.sv]
`include "serial_params.svh"
package serial_pkg;
   // Register port request
   typedef struct packed {
      logic [`SER_ADDR_W-1:0] addr;
      logic [`SER_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
      logic transfer_controller;
   } bus_req_t;
   // Received character from the receive shifter
   typedef struct packed {
      logic done;
      logic [`SER_DATA_W-1:0] data;
      logic par;
      logic mp_rx_bit;
   } rx_evt_t;
   // Character handed to the transmit shifter
   typedef struct packed {
      logic start;
      logic [`SER_DATA_W-1:0] data;
      logic mp_en;
      logic mp_bit;
   } tx_req_t;
   // Baud generator state
   typedef struct packed {
      logic [`PRE_W-1:0] pre;
      logic [`SER_DATA_W-1:0] div;
      logic [`SUB_W-1:0] sub;
      logic tick;
      logic bit_tick;
   } baud_state_t;
   // Status, control and register state
   typedef struct packed {
      logic [`SER_DATA_W-1:0] mode;
      logic [`SER_DATA_W-1:0] bit_rate_divisor;
      logic te;
      logic re;
      logic [`SER_DATA_W-1:0] transmit_data_reg;
      logic [`SER_DATA_W-1:0] receive_data_reg;
      logic transmit_empty_flag;
      logic receive_full_flag;
      logic parity_error_flag;
      logic transmit_end_flag;
      logic mp_rx_bit;
      logic mp_tx_bit;
      logic arm_transmit_empty_flag;
      logic arm_receive_full_flag;
      logic arm_per;
      logic tx_busy;
      logic [`IRQ_W-1:0] ists;
      logic [`IRQ_W-1:0] imask;
      logic [`SER_DATA_W-1:0] rdata;
      logic irq;
      tx_req_t tx;
      logic rx_blk;
      logic tx_blk;
   } ctl_state_t;
endpackage

// [parity_check.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"
// Flags a character whose one count disagrees with the chosen parity
module parity_check (
   // Character and its parity bit
   input wire logic [`SER_DATA_W-1:0] data,
   input wire logic par,
   // One selects odd parity
   input wire logic odd,
   // High on mismatch
   output logic err
);
   // Odd total count of ones is right only for odd parity
   assign err = ((^data) ^ par) != odd;
endmodule
`default_nettype wire

// [bit_rate_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"
// Per-channel baud generator: prescaler, divisor, bit subdivider
module bit_rate_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Run while either direction is enabled
   input wire logic run,
   // Clock select and divisor
   input wire logic [1:0] cks,
   input wire logic [`SER_DATA_W-1:0] bit_rate_divisor,
   // Sampling tick and bit tick
   output logic tick,
   output logic bit_tick
);
   import serial_pkg::*;
   baud_state_t st_r;
   baud_state_t st_nxt;
   logic [`PRE_W-1:0] pre_lim;
   // Prescaler limit from clock select, 4 to the power n minus one
   always_comb begin
      unique case (cks)
         2'h0: pre_lim = `PRE_LIM0;
         2'h1: pre_lim = `PRE_LIM1;
         2'h2: pre_lim = `PRE_LIM2;
         2'h3: pre_lim = `PRE_LIM3;
      endcase
   end
   // Bit time is 32 * 4^n * (divisor + 1) system clocks
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      st_nxt.bit_tick = 1'b0;
      if (!run) begin
         // Idle: hold everything at the start of a bit
         st_nxt.pre = '0;
         st_nxt.div = '0;
         st_nxt.sub = '0;
      end else if (st_r.pre != pre_lim) begin
         st_nxt.pre = st_r.pre + 1'b1;
      end else begin
         st_nxt.pre = '0;
         if (st_r.div < bit_rate_divisor) begin
            st_nxt.div = st_r.div + 1'b1;
         end else begin
            st_nxt.div = '0;
            st_nxt.tick = 1'b1;
            st_nxt.sub = st_r.sub + 1'b1;
            st_nxt.bit_tick = (st_r.sub == `SUB_LIM);
         end
      end
   end
   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign tick = st_r.tick;
   assign bit_tick = st_r.bit_tick;
endmodule
`default_nettype wire

// [serial_status_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"
module serial_status_top (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Low power states
   input wire logic STANDBY,
   input wire logic MODULE_STOP,
   // Register port
   input wire serial_pkg::bus_req_t BUS_REQ,
   output logic [`SER_DATA_W-1:0] BUS_RDATA,
   // Receive shifter
   input wire serial_pkg::rx_evt_t RX_EVT,
   // Transmit shifter
   input wire logic TX_LAST_BIT,
   output serial_pkg::tx_req_t TX_REQ,
   // Channel control
   output logic RX_ENABLE,
   output logic TX_ENABLE,
   output logic SYNC_MODE,
   output logic RX_BLOCK,
   output logic TX_BLOCK,
   // Baud timing
   output logic BAUD_TICK,
   output logic BIT_TICK,
   // Interrupt
   output logic IRQ
);
   import serial_pkg::*;

   ctl_state_t st_r; // Whole register state
   ctl_state_t st_nxt; // Its next value
   logic par_err; // Parity mismatch of incoming char
   logic wr_hit; // Write strobe present
   logic rd_hit; // Read strobe present
   logic sync_m; // Clocked synchronous mode
   logic mp_m; // Multiprocessor format
   logic rx_take; // Character accepted this cycle
   logic tx_go; // Character launched this cycle
   logic [`SER_DATA_W-1:0] wd; // Write data alias
   logic [`SER_DATA_W-1:0] stat_v; // Assembled status byte

   assign wr_hit = BUS_REQ.wr;
   assign rd_hit = BUS_REQ.rd;
   assign wd = BUS_REQ.wdata;
   assign sync_m = st_r.mode[`MODE_SYNC];
   assign mp_m = st_r.mode[`MODE_MP] && !sync_m;

   // Parity of each received character
   parity_check u_par (
      .data(RX_EVT.data),
      .par(RX_EVT.par),
      .odd(st_r.mode[`MODE_ODD]),
      .err(par_err)
   );

   // Own generator instance per channel, fed by its own divisor
   bit_rate_gen u_brg (
      .clk(CLK_SYS),
      .rst(RST),
      .run(st_r.te || st_r.re),
      .cks(st_r.mode[`MODE_CKS_HI:`MODE_CKS_LO]),
      .bit_rate_divisor(st_r.bit_rate_divisor),
      .tick(BAUD_TICK),
      .bit_tick(BIT_TICK)
   );

   // Reception is refused while a parity error is pending
   assign rx_take = RX_EVT.done && st_r.re && !st_r.parity_error_flag;
   // Launch when data waits, shifter idle and not blocked
   assign tx_go = st_r.te && !st_r.transmit_empty_flag && !st_r.tx_busy
      && !st_r.tx_blk;

   // Status byte as software sees it
   always_comb begin
      stat_v = `BYTE_ZERO;
      stat_v[`ST_TRANSMIT_EMPTY_FLAG] = st_r.transmit_empty_flag;
      stat_v[`ST_RECEIVE_FULL_FLAG] = st_r.receive_full_flag;
      stat_v[`ST_PER] = st_r.parity_error_flag;
      stat_v[`ST_TRANSMIT_END_FLAG] = st_r.transmit_end_flag;
      stat_v[`ST_MPB] = st_r.mp_rx_bit;
      stat_v[`ST_MP_TX_BIT] = st_r.mp_tx_bit;
   end

   // Next state: software accesses first, hardware events last
   always_comb begin
      st_nxt = st_r;
      st_nxt.tx.start = 1'b0;
      st_nxt.rdata = `BYTE_ZERO;

      // Register reads, answered in the following cycle
      if (rd_hit) begin
         unique case (BUS_REQ.addr)
            `OFS_MODE: st_nxt.rdata = st_r.mode;
            `OFS_BRR: st_nxt.rdata = st_r.bit_rate_divisor;
            `OFS_CTRL: begin
               st_nxt.rdata[`CTL_TE] = st_r.te;
               st_nxt.rdata[`CTL_RE] = st_r.re;
            end
            `OFS_TDR: st_nxt.rdata = st_r.transmit_data_reg;
            `OFS_STAT: begin
               st_nxt.rdata = stat_v;
               // Remember which flags were seen set
               st_nxt.arm_transmit_empty_flag = st_r.transmit_empty_flag;
               st_nxt.arm_receive_full_flag = st_r.receive_full_flag;
               st_nxt.arm_per = st_r.parity_error_flag;
            end
            `OFS_RDR: st_nxt.rdata = st_r.receive_data_reg;
            `OFS_ISTS: st_nxt.rdata[`IRQ_W-1:0] = st_r.ists;
            `OFS_IMASK: st_nxt.rdata[`IRQ_W-1:0] = st_r.imask;
            // Unmapped offsets read as zero
            default: st_nxt.rdata = `BYTE_ZERO;
         endcase
      end

      // Register writes
      if (wr_hit) begin
         unique case (BUS_REQ.addr)
            `OFS_MODE: st_nxt.mode = wd;
            `OFS_BRR: st_nxt.bit_rate_divisor = wd;
            `OFS_CTRL: begin
               st_nxt.te = wd[`CTL_TE];
               st_nxt.re = wd[`CTL_RE];
            end
            `OFS_TDR: begin
               st_nxt.transmit_data_reg = wd;
               // Transfer controller write also empties the flags
               if (BUS_REQ.transfer_controller) begin
                  st_nxt.transmit_empty_flag = 1'b0;
                  st_nxt.transmit_end_flag = 1'b0;
               end
            end
            `OFS_STAT: begin
               // Zero clears only after the flag was read as one
               if (!wd[`ST_PER] && st_r.arm_per) begin
                  st_nxt.parity_error_flag = 1'b0;
                  st_nxt.arm_per = 1'b0;
               end
               if (!wd[`ST_RECEIVE_FULL_FLAG] && st_r.arm_receive_full_flag) begin
                  st_nxt.receive_full_flag = 1'b0;
                  st_nxt.arm_receive_full_flag = 1'b0;
               end
               if (!wd[`ST_TRANSMIT_EMPTY_FLAG] && st_r.arm_transmit_empty_flag) begin
                  st_nxt.transmit_empty_flag = 1'b0;
                  st_nxt.transmit_end_flag = 1'b0;
                  st_nxt.arm_transmit_empty_flag = 1'b0;
               end
               // End flag and received bit are read-only
               st_nxt.mp_tx_bit = wd[`ST_MP_TX_BIT];
            end
            // Sticky interrupt bits clear by writing one
            `OFS_ISTS: st_nxt.ists = st_r.ists & ~wd[`IRQ_W-1:0];
            `OFS_IMASK: st_nxt.imask = wd[`IRQ_W-1:0];
            // Writes elsewhere are dropped
            default: st_nxt.mode = st_r.mode;
         endcase
      end

      // Receive: flags untouched when only the enable drops
      if (rx_take) begin
         st_nxt.receive_data_reg = RX_EVT.data;
         if (st_r.mode[`MODE_PAR_EN] && !sync_m && par_err) begin
            st_nxt.parity_error_flag = 1'b1;
            st_nxt.ists[`IRQ_PER] = 1'b1;
         end else begin
            st_nxt.receive_full_flag = 1'b1;
            st_nxt.ists[`IRQ_RXF] = 1'b1;
         end
         if (mp_m) begin
            st_nxt.mp_rx_bit = RX_EVT.mp_rx_bit;
         end
      end

      // Transmit launch: data moves to the shifter
      if (tx_go) begin
         st_nxt.tx.start = 1'b1;
         st_nxt.tx.data = st_r.transmit_data_reg;
         st_nxt.tx.mp_en = mp_m;
         // Bit is only meaningful in asynchronous multiprocessor use
         st_nxt.tx.mp_bit = mp_m && st_r.mp_tx_bit;
         st_nxt.transmit_empty_flag = 1'b1;
         st_nxt.tx_busy = 1'b1;
         st_nxt.ists[`IRQ_TXE] = 1'b1;
      end

      // Last bit out: end only when nothing waits in the data reg
      if (TX_LAST_BIT && st_r.tx_busy) begin
         st_nxt.tx_busy = tx_go;
         if (st_r.transmit_empty_flag && !tx_go) begin
            st_nxt.transmit_end_flag = 1'b1;
            st_nxt.ists[`IRQ_TRANSMIT_END_FLAG] = 1'b1;
         end
      end

      // Disabled transmitter always reports end
      if (!st_r.te) begin
         st_nxt.transmit_end_flag = 1'b1;
         st_nxt.tx_busy = 1'b0;
      end

      // Low power entry forces the divisor back to all ones
      if (STANDBY || MODULE_STOP) begin
         st_nxt.bit_rate_divisor = `BRR_RST;
      end

      // Receive block follows the pending parity error, transmit block only in sync mode
      st_nxt.rx_blk = st_nxt.parity_error_flag;
      st_nxt.tx_blk = st_nxt.parity_error_flag && st_nxt.mode[`MODE_SYNC];

      // Level interrupt, registered so the pin is glitch free
      st_nxt.irq = |(st_nxt.ists & st_nxt.imask);
   end

   // State register, reset values spelt out per field
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_r.mode <= `MODE_RST;
         st_r.bit_rate_divisor <= `BRR_RST;
         st_r.te <= 1'b0;
         st_r.re <= 1'b0;
         st_r.transmit_data_reg <= `BYTE_ZERO;
         st_r.receive_data_reg <= `BYTE_ZERO;
         st_r.transmit_empty_flag <= 1'b1;
         st_r.receive_full_flag <= 1'b0;
         st_r.parity_error_flag <= 1'b0;
         st_r.transmit_end_flag <= 1'b1;
         st_r.mp_rx_bit <= 1'b0;
         st_r.mp_tx_bit <= 1'b0;
         st_r.arm_transmit_empty_flag <= 1'b0;
         st_r.arm_receive_full_flag <= 1'b0;
         st_r.arm_per <= 1'b0;
         st_r.tx_busy <= 1'b0;
         st_r.ists <= `IRQ_ZERO;
         st_r.imask <= `IRQ_ZERO;
         st_r.rdata <= `BYTE_ZERO;
         st_r.irq <= 1'b0;
         st_r.tx <= '0;
         st_r.rx_blk <= 1'b0;
         st_r.tx_blk <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign BUS_RDATA = st_r.rdata;
   assign TX_REQ = st_r.tx;
   assign RX_ENABLE = st_r.re;
   assign TX_ENABLE = st_r.te;
   assign SYNC_MODE = st_r.mode[`MODE_SYNC];
   assign RX_BLOCK = st_r.rx_blk;
   assign TX_BLOCK = st_r.tx_blk;
   assign IRQ = st_r.irq;
endmodule
`default_nettype wire

// [serial_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"
// Port-level checks of the status and divisor block
module serial_status_monitor (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Register port
   input wire serial_pkg::bus_req_t BUS_REQ,
   input wire logic [`SER_DATA_W-1:0] BUS_RDATA,
   // Shifter sides
   input wire serial_pkg::rx_evt_t RX_EVT,
   input wire serial_pkg::tx_req_t TX_REQ,
   // Channel state
   input wire logic RX_ENABLE,
   input wire logic TX_ENABLE,
   input wire logic SYNC_MODE,
   input wire logic RX_BLOCK,
   input wire logic TX_BLOCK,
   input wire logic BAUD_TICK,
   input wire logic IRQ
);
   import serial_pkg::*;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // Block only ever rises on a received character
   AST_PER_CAUSE: assert property (
      $rose(RX_BLOCK) |-> $past(RX_EVT.done))
      else $error("parity block rose with no character");
   // Only a bus write can drop the flag
   AST_PER_HOLD: assert property (RX_BLOCK && !BUS_REQ.wr |=> RX_BLOCK)
      else $error("parity block dropped without a write");
   AST_PER_CLEAR: assert property ($fell(RX_BLOCK) |->
      $past(BUS_REQ.wr) && $past(BUS_REQ.addr) == `OFS_STAT
      && !$past(BUS_REQ.wdata[`ST_PER]))
      else $error("parity block fell without a zero write");
   // Receive disable leaves the flag alone
   AST_RE_OFF: assert property ($fell(RX_ENABLE) |-> $stable(RX_BLOCK))
      else $error("receive disable moved the parity block");
   AST_TX_BLK: assert property (TX_BLOCK |-> RX_BLOCK && SYNC_MODE)
      else $error("transmit block without parity flag in sync mode");
   AST_TX_LAUNCH: assert property (TX_REQ.start |->
      $past(TX_ENABLE) && !$past(TX_BLOCK))
      else $error("character launched while disabled or blocked");
   // Sync mode never carries a multiprocessor bit
   AST_MP_SYNC: assert property (
      TX_REQ.start && SYNC_MODE |-> !TX_REQ.mp_bit)
      else $error("multiprocessor bit sent in sync mode");
   AST_RDATA_IDLE: assert property (
      !$past(BUS_REQ.rd) |-> BUS_RDATA == 8'h00)
      else $error("read data outside the answer cycle");
   // Generator stays quiet once both directions are off
   AST_BAUD_OFF: assert property (
      (!TX_ENABLE && !RX_ENABLE)[*3] |-> !BAUD_TICK)
      else $error("baud tick with both directions off");
   COV_PER: cover property ($rose(RX_BLOCK));
   COV_MP: cover property (TX_REQ.start && TX_REQ.mp_bit);
   COV_IRQ: cover property ($rose(IRQ));
endmodule
bind serial_status_top serial_status_monitor serial_status_monitor_i (
   .CLK_SYS(CLK_SYS), .RST(RST), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
   .RX_EVT(RX_EVT), .TX_REQ(TX_REQ), .RX_ENABLE(RX_ENABLE),
   .TX_ENABLE(TX_ENABLE), .SYNC_MODE(SYNC_MODE), .RX_BLOCK(RX_BLOCK),
   .TX_BLOCK(TX_BLOCK), .BAUD_TICK(BAUD_TICK), .IRQ(IRQ));
`default_nettype wire

// [serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the shifters and the remote end of the link
module serial_peer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Character from the block
   input wire serial_pkg::tx_req_t tx_req,
   // Received characters and end of transmission
   output var serial_pkg::rx_evt_t rx_evt,
   output logic last_bit
);
   import serial_pkg::*;
   int gap = 5; // Cycles per character, raised by the bench for slow ends
   // Ends each started character after the chosen delay
   initial begin
      last_bit = 1'b0;
      rx_evt = '0;
      forever begin
         @(posedge clk);
         if (tx_req.start && !rst) begin
            repeat (gap) @(posedge clk);
            last_bit <= 1'b1;
            @(posedge clk);
            last_bit <= 1'b0;
         end
      end
   end
   // One character; lines scrambled afterwards so no stale value passes
   task automatic send(input logic [7:0] d, input logic p, input logic m);
      @(posedge clk);
      rx_evt <= '{done: 1'b1, data: d, par: p, mp_rx_bit: m};
      @(posedge clk);
      rx_evt <= '{done: 1'b0, data: ~d, par: ~p, mp_rx_bit: ~m};
   endtask
endmodule
`default_nettype wire

// [test_serial_status_and_bit_rate.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"
module test_serial_status_and_bit_rate;
   import serial_pkg::*;
   logic clk_sys, rst, standby, module_stop, tx_last_bit;
   logic rx_en, tx_en, sync_mode, rx_blk, tx_blk, baud_tick, bit_tick, irq;
   bus_req_t bus_req;
   logic [7:0] bus_rdata;
   logic [7:0] d;
   rx_evt_t rx_evt;
   tx_req_t tx_req;
   int errors = 0;
   int n_tests = 0;
   int i, g;
   serial_status_top serial_status_top_i (.CLK_SYS(clk_sys), .RST(rst),
      .STANDBY(standby), .MODULE_STOP(module_stop), .BUS_REQ(bus_req),
      .BUS_RDATA(bus_rdata), .RX_EVT(rx_evt), .TX_LAST_BIT(tx_last_bit),
      .TX_REQ(tx_req), .RX_ENABLE(rx_en), .TX_ENABLE(tx_en),
      .SYNC_MODE(sync_mode), .RX_BLOCK(rx_blk), .TX_BLOCK(tx_blk),
      .BAUD_TICK(baud_tick), .BIT_TICK(bit_tick), .IRQ(irq));
   serial_peer serial_peer_i (.clk(clk_sys), .rst(rst), .tx_req(tx_req),
      .rx_evt(rx_evt), .last_bit(tx_last_bit));
   // 250 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string w, input logic [7:0] e,
      input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", w, e, s);
         errors++;
      end
   endtask
   // Register port: one-cycle strobes, data in the following cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic t);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0, transfer_controller: t};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, transfer_controller: 1'b0};
      @(posedge clk_sys);
      bus_req <= '0;
      #1;
      v = bus_rdata;
   endtask
   task automatic rchk(input string w, input logic [3:0] a,
      input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(w, e, v);
   endtask
   // Bounded wait for a start (1) or last bit (0)
   task automatic wait_sig(input logic sel);
      for (int k = 0; k < 200; k++) begin
         @(posedge clk_sys);
         #1;
         if (sel ? tx_req.start : tx_last_bit)
            return;
      end
      errors++;
      $display("ERROR transmit handshake expected 1 seen 0");
      stop_test();
   endtask
   // Cycles between two ticks of the chosen kind, bounded
   task automatic tick_gap(input logic sel, output int n);
      int f;
      f = -1;
      n = -1;
      for (int k = 0; k < 4000 && n < 0; k++) begin
         @(posedge clk_sys);
         #1;
         if (sel ? bit_tick : baud_tick) begin
            if (f >= 0)
               n = k - f;
            else
               f = k;
         end
      end
      if (n < 0)
         chk("tick", 8'h01, 8'h00);
   endtask
   // Transmit one character by read, then zero write of the empty flag
   task automatic launch(input logic [7:0] v);
      wr(`OFS_TDR, v, 1'b0);
      rd(`OFS_STAT, d);
      wr(`OFS_STAT, 8'h7D, 1'b0);
      wait_sig(1'b1);
   endtask
   initial begin
      rst = 1'b1;
      standby = 1'b0;
      module_stop = 1'b0;
      bus_req = '0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rchk("divisor", `OFS_BRR, `BRR_RST);
      rchk("status", `OFS_STAT, 8'h84);
      rchk("unmapped", 4'hA, 8'h00);
      // Divisor survives writes, low power entry forces it back
      for (i = 0; i < 2; i++) begin
         wr(`OFS_BRR, 8'h5A, 1'b0);
         rchk("divisor", `OFS_BRR, 8'h5A);
         standby <= (i == 0);
         module_stop <= (i == 1);
         @(posedge clk_sys);
         standby <= 1'b0;
         module_stop <= 1'b0;
         rchk("divisor", `OFS_BRR, `BRR_RST);
      end
      $display("test divisor done");
      // Tick spacing for every clock select, divisor two
      wr(`OFS_BRR, 8'h02, 1'b0);
      wr(`OFS_CTRL, 8'h10, 1'b0);
      for (i = 0; i < 4; i++) begin
         wr(`OFS_MODE, 8'(i), 1'b0);
         tick_gap(1'b0, g);
         tick_gap(1'b0, g);
         chk("baud gap", 8'((4 ** i) * 3), 8'(g));
      end
      wr(`OFS_MODE, 8'h00, 1'b0);
      tick_gap(1'b1, g);
      chk("bit gap", 8'h60, 8'(g));
      $display("test baud done");
      // Good odd parity, then bad even parity
      wr(`OFS_MODE, 8'h30, 1'b0);
      serial_peer_i.send(8'h01, 1'b0, 1'b0);
      rchk("rx data", `OFS_RDR, 8'h01);
      rchk("status", `OFS_STAT, 8'hC4);
      wr(`OFS_STAT, 8'hBE, 1'b0);
      wr(`OFS_MODE, 8'h20, 1'b0);
      serial_peer_i.send(8'h07, 1'b0, 1'b0);
      rchk("status", `OFS_STAT, 8'h8C);
      rchk("rx data", `OFS_RDR, 8'h07);
      chk("rx block", 8'h01, {7'h00, rx_blk});
      serial_peer_i.send(8'h55, 1'b1, 1'b0);
      rchk("rx data", `OFS_RDR, 8'h07);
      chk("irq masked", 8'h00, {7'h00, irq});
      wr(`OFS_IMASK, 8'h04, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("irq", 8'h01, {7'h00, irq});
      wr(`OFS_CTRL, 8'h00, 1'b0);
      rchk("status", `OFS_STAT, 8'h8C);
      // Pending parity error in sync mode also holds the transmitter
      wr(`OFS_MODE, 8'hA0, 1'b0);
      #1;
      chk("tx block", 8'h03, {6'h00, sync_mode, tx_blk});
      wr(`OFS_STAT, 8'hF6, 1'b0);
      rchk("status", `OFS_STAT, 8'h84);
      chk("tx block", 8'h02, {6'h00, sync_mode, tx_blk});
      wr(`OFS_ISTS, 8'h04, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("irq cleared", 8'h00, {7'h00, irq});
      $display("test parity done");
      // Multiprocessor bit kept across receive disable
      wr(`OFS_MODE, 8'h04, 1'b0);
      wr(`OFS_CTRL, 8'h10, 1'b0);
      serial_peer_i.send(8'h11, 1'b0, 1'b1);
      wr(`OFS_CTRL, 8'h00, 1'b0);
      rchk("status", `OFS_STAT, 8'hC6);
      wr(`OFS_STAT, 8'hBF, 1'b0);
      $display("test mp receive done");
      // Transmit with multiprocessor bit, slow far end
      serial_peer_i.gap = 20;
      wr(`OFS_CTRL, 8'h20, 1'b0);
      #1;
      chk("enables", 8'h02, {6'h00, tx_en, rx_en});
      launch(8'hA5);
      chk("tx data", 8'hA5, tx_req.data);
      chk("tx mp", 8'h03, {6'h00, tx_req.mp_en, tx_req.mp_bit});
      // Received multiprocessor bit from the earlier test still reads one
      rchk("status", `OFS_STAT, 8'h83);
      wait_sig(1'b0);
      rchk("status", `OFS_STAT, 8'h87);
      wr(`OFS_STAT, 8'hFB, 1'b0);
      rchk("status", `OFS_STAT, 8'h87);
      wr(`OFS_TDR, 8'h3C, 1'b1);
      wait_sig(1'b1);
      chk("tx data", 8'h3C, tx_req.data);
      rchk("status", `OFS_STAT, 8'h83);
      wait_sig(1'b0);
      // Sync mode drops the multiprocessor bit
      wr(`OFS_MODE, 8'h84, 1'b0);
      launch(8'h96);
      chk("tx mp sync", 8'h00, {7'h00, tx_req.mp_bit});
      wr(`OFS_CTRL, 8'h00, 1'b0);
      rchk("status", `OFS_STAT, 8'h87);
      $display("test transmit done");
      stop_test();
   end
endmodule
`default_nettype wire
